// ### test/ssd_chk.sv
`timescale 1ns/1ps
`default_nettype none
module ssd_chk (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hsel,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire ssd_pkg::ssd_link_in_t link_in,
  input wire logic miso_o,
  input wire logic miso_oe,
  input wire ssd_pkg::ssd_dma_req_t dma_req,
  input wire logic irq
);
  import ssd_pkg::*;
  logic w_q;
  logic [7:0] wa_q;
  logic [31:0] ic_q;
  logic [1:0] ie_q;
  wire logic acc = hsel && hready && htrans == HTRANS_NONSEQ &&
    hsize == HSIZE_WORD;
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      w_q <= 1'b0;
      wa_q <= 8'h00;
    end else if (hready) begin
      w_q <= acc && hwrite;
      wa_q <= haddr[7:0];
    end
  end
  // Shadow copies of the enables, so gating can be judged at the ports
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ic_q <= 32'h00002100;
      ie_q <= 2'h0;
    end else if (w_q && hready) begin
      if (wa_q == ADDR_IRQ_DMA_CTRL) ic_q <= hwdata;
      if (wa_q == ADDR_INT_ENABLE) ie_q <= hwdata[1:0];
    end
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  sequence s_tdma_off;
    !ic_q[IC_TDMA_BIT] [*4];
  endsequence
  sequence s_rdma_off;
    !ic_q[IC_RDMA_BIT] [*4];
  endsequence
  chk_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus answer not ready or not okay");
  chk_reset_quiet: assert property (disable iff (1'b0)
    sys_rst |-> !irq && dma_req == '0 && !miso_oe)
    else $error("outputs active during reset");
  chk_oe_release: assert property (link_in.cs_n [*6] |-> !miso_oe)
    else $error("serial output driven while deselected");
  chk_rdata_idle: assert property (
    !$past(acc && !hwrite) |-> hrdata == 32'h0)
    else $error("read data shown without a read access");
  chk_txdma_gate: assert property (s_tdma_off |-> !dma_req.tx_req)
    else $error("transmit request while its enable is clear");
  chk_rxdma_gate: assert property (s_rdma_off |-> !dma_req.rx_req)
    else $error("receive request while its enable is clear");
  chk_txthr_zero: assert property (
    (ic_q[IC_TTH_LO+:TH_W] == '0) [*4] |-> !dma_req.tx_req)
    else $error("transmit request with zero threshold");
  chk_rxthr_zero: assert property (
    (ic_q[IC_RTH_LO+:TH_W] == '0) [*4] |-> !dma_req.rx_req)
    else $error("receive request with zero threshold");
  chk_irq_masked: assert property (
    (ic_q[3:0] == 4'h0 && ie_q == 2'h0) [*4] |-> !irq)
    else $error("interrupt raised with every source masked");
endmodule // ssd_chk
bind ssd_top ssd_chk ssd_chk_inst (.ref_clk(ref_clk), .sys_rst(sys_rst),
  .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
  .hwdata(hwdata), .hsel(hsel), .hready(hready), .hrdata(hrdata),
  .hreadyout(hreadyout), .hresp(hresp), .link_in(link_in),
  .miso_o(miso_o), .miso_oe(miso_oe), .dma_req(dma_req), .irq(irq));
`default_nettype wire

// ### test/ssd_spi_master.sv
`timescale 1ns/1ps
`default_nettype none
module ssd_spi_master (
  output var ssd_pkg::ssd_link_in_t link,
  input wire logic miso_o,
  input wire logic miso_oe
);
  import ssd_pkg::*;
  logic [31:0] rx;
  initial link = '{sck: 1'b0, cs_n: 1'b1, mosi: 1'b0};
  // Mode 0 master; sck stands still low between frames
  task automatic xfer(input logic [31:0] tx, input int n, input int half);
    // Keep pin changes off the sampling edges of the system clock
    #(half / 16);
    link.cs_n = 1'b0;
    #(half);
    for (int i = 0; i < n; i++) begin
      link.mosi = tx[31-i];
      #(half);
      link.sck = 1'b1;
      #(half);
      // Sample late in the high phase: the slave's output lags its pins
      rx = {rx[30:0], miso_oe ? miso_o : ~rx[0]};
      link.sck = 1'b0;
    end
    // Released data line must not keep showing the last bit
    link.mosi = ~link.mosi;
    // A short count leaves the word hanging with cs_n low
    if (n == 32) begin
      #(half);
      link.cs_n = 1'b1;
      #(2 * half);
    end
  endtask
endmodule // ssd_spi_master
`default_nettype wire

// ### test/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
  import ssd_pkg::*;
  logic ref_clk, sys_rst, hwrite, hsel, hreadyout, hresp;
  logic miso_o, miso_oe, irq;
  logic [31:0] haddr, hwdata, hrdata, q;
  logic [1:0] htrans;
  logic [2:0] hsize;
  ssd_link_in_t link_in;
  ssd_dma_req_t dma_req;
  int err_count, n_tests;
  ssd_top ssd_top_inst (.ref_clk(ref_clk), .sys_rst(sys_rst),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hsel(hsel), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .link_in(link_in),
    .miso_o(miso_o), .miso_oe(miso_oe), .dma_req(dma_req), .irq(irq));
  ssd_spi_master ssd_spi_master_inst (.link(link_in), .miso_o(miso_o),
    .miso_oe(miso_oe));
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    n_tests++;
    if (s !== e) begin
      err_count++;
      $display("Error at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic report_and_stop;
    if (err_count == 0 && n_tests > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic bus(input logic [7:0] a, input logic w,
    input logic [31:0] d);
    int n;
    n = 0;
    @(posedge ref_clk);
    haddr <= {24'h0, a};
    hwrite <= w;
    htrans <= HTRANS_NONSEQ;
    hsize <= HSIZE_WORD;
    hsel <= 1'b1;
    do begin @(posedge ref_clk); n++; end while (hreadyout !== 1'b1 && n < 50);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    do begin @(posedge ref_clk); n++; end while (hreadyout !== 1'b1 && n < 100);
    q = hrdata;
    if (n >= 100) begin
      err_count++;
      report_and_stop();
    end
  endtask
  task automatic settle;
    repeat (3) @(posedge ref_clk);
  endtask
  function automatic logic [31:0] st(input int rl, tl, b, nf, rf);
    return 32'((tl << ST_TXL_LO) | (rl << ST_RXL_LO) | (b << ST_BUSY_BIT)
      | (nf << ST_TNF_BIT) | rf);
  endfunction
  function automatic logic [31:0] word(input int i);
    return {24'h9c3a51, 8'(i)};
  endfunction
  initial begin
    #5000000;
    err_count++;
    report_and_stop();
  end
  initial begin
    int k;
    logic [31:0] base;
    sys_rst = 1'b1;
    {haddr, hwdata, htrans, hwrite, hsize, hsel} = '0;
    err_count = 0;
    n_tests = 0;
    repeat (4) @(posedge ref_clk);
    sys_rst <= 1'b0;
    bus(ADDR_STATUS, 0, 0); chk(q, st(0, 0, 0, 1, 0));
    bus(ADDR_IRQ_DMA_CTRL, 0, 0); chk(q, 32'h00002100);
    bus(8'h40, 0, 0); chk(q, 32'h0);
    // Ninth write finds the FIFO full and must be dropped
    for (int i = 1; i <= 9; i++) begin
      k = (i > 8) ? 8 : i;
      bus(ADDR_DATA, 1, word(i));
      bus(ADDR_STATUS, 0, 0); chk(q, st(0, k, 0, k < 8, 0));
    end
    for (int j = 0; j < 3; j++) begin
      base = 32'((j < 2) << IC_TDMA_BIT) | 32'((7 + (j > 0)) << IC_TTH_LO);
      bus(ADDR_IRQ_DMA_CTRL, 1, base);
      settle(); chk(dma_req.tx_req, j == 1);
    end
    base = 32'(1 << IC_RDMA_BIT) | 32'(8 << IC_RTH_LO);
    bus(ADDR_IRQ_DMA_CTRL, 1, base);
    bus(ADDR_CTRL, 1, 32'h1);
    for (k = 1; k <= 9; k++) begin
      fork
        ssd_spi_master_inst.xfer(~word(k), 32, 400);
        begin
          repeat (40) @(posedge ref_clk);
          bus(ADDR_STATUS, 0, 0); chk(q[ST_BUSY_BIT], 1);
        end
      join
      chk(ssd_spi_master_inst.rx, (k < 9) ? word(k) : 32'h0);
      bus(ADDR_STATUS, 0, 0);
      chk(q, st((k > 8) ? 8 : k, (k > 8) ? 0 : 8 - k, 0, 1, k >= 8));
      chk(dma_req.rx_req, k >= 8);
    end
    chk(dma_req.tx_req, 0);
    chk(irq, 0);
    for (int e = 0; e < 4; e++) begin
      bus(ADDR_IRQ_DMA_CTRL, 1, base | 32'(1 << e));
      settle(); chk(irq, e < 3);
    end
    bus(ADDR_IRQ_DMA_CTRL, 1, base | 32'h1);
    bus(ADDR_INT_STATUS, 0, 0); chk(q & 32'h3, 32'h3);
    settle(); chk(irq, 0);
    bus(ADDR_INT_STATUS, 0, 0); chk(q & 32'h3, 32'h0);
    bus(ADDR_DATA, 0, 0); chk(q, ~word(1));
    bus(ADDR_STATUS, 0, 0); chk(q, st(7, 0, 0, 1, 0));
    // Master stops its clock mid-word: only a soft reset recovers
    ssd_spi_master_inst.xfer(32'h0f0f0f0f, 8, 400);
    bus(ADDR_STATUS, 0, 0); chk(q[ST_BUSY_BIT], 1);
    bus(ADDR_CTRL, 1, 32'h1);
    bus(ADDR_STATUS, 0, 0); chk(q[ST_BUSY_BIT], 1);
    bus(ADDR_CTRL, 1, 32'h0);
    bus(ADDR_CTRL, 1, 32'(1 << CTRL_SRST_BIT));
    bus(ADDR_STATUS, 0, 0); chk(q[ST_BUSY_BIT], 0);
    report_and_stop();
  end
endmodule // tb
`default_nettype wire

// ### verilog/ssd_pkg.sv
package ssd_pkg;

  // Register byte offsets
  localparam logic [7:0] ADDR_CTRL = 8'h08;
  localparam logic [7:0] ADDR_STATUS = 8'h0c;
  localparam logic [7:0] ADDR_IRQ_DMA_CTRL = 8'h10;
  localparam logic [7:0] ADDR_INT_STATUS = 8'h14;
  localparam logic [7:0] ADDR_DATA = 8'h18;
  localparam logic [7:0] ADDR_INT_CLEAR = 8'h1c;
  localparam logic [7:0] ADDR_INT_ENABLE = 8'h20;

  // Fixed depths; must stay within the six-bit level fields
  localparam int TX_DEPTH = 8;
  localparam int RX_DEPTH = 8;
  localparam int LVL_W = 6;
  localparam int PTR_W = 3;

  // Control register bit positions
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_SRST_BIT = 6;

  // Status register field positions
  localparam int ST_RXF_BIT = 0;
  localparam int ST_TNF_BIT = 1;
  localparam int ST_BUSY_BIT = 2;
  localparam int ST_RXL_LO = 4;
  localparam int ST_TXL_LO = 12;

  // Interrupt/DMA control field positions
  localparam int IC_ORIE_BIT = 0;
  localparam int IC_URIE_BIT = 1;
  localparam int IC_RTIE_BIT = 2;
  localparam int IC_TTIE_BIT = 3;
  localparam int IC_RDMA_BIT = 4;
  localparam int IC_TDMA_BIT = 5;
  localparam int IC_RTH_LO = 7;
  localparam int IC_TTH_LO = 12;
  localparam int TH_W = 5;
  localparam logic [TH_W-1:0] TH_RESET = 5'h02;

  // Sticky event bit positions
  localparam int EV_OVR = 0;
  localparam int EV_UND = 1;
  localparam int EV_W = 2;

  localparam int WORD_W = 32;
  localparam int BITCNT_W = 5;
  localparam logic [BITCNT_W-1:0] LAST_BIT = 5'h1f;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0] HSIZE_WORD = 3'h2;

  typedef enum logic [0:0] {
    SSD_IDLE = 1'b0,
    SSD_SHIFT = 1'b1
  } ssd_state_t;

  typedef struct packed {
    logic sck;
    logic cs_n;
    logic mosi;
  } ssd_link_in_t;

  typedef struct packed {
    logic tx_req;
    logic rx_req;
  } ssd_dma_req_t;

endpackage

// ### verilog/ssd_top.sv
`timescale 1ns/1ps
`default_nettype none
module ssd_top (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hsel,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire ssd_pkg::ssd_link_in_t link_in,
  output logic miso_o,
  output logic miso_oe,
  output ssd_pkg::ssd_dma_req_t dma_req,
  output logic irq
);
  import ssd_pkg::*;

  // Two-flop synchronisers for the serial pins
  ssd_link_in_t sync1_q, sync2_q;
  logic sck_prev_q;
  logic sel_prev_q;
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      sync1_q <= '{sck: 1'b0, cs_n: 1'b1, mosi: 1'b0};
      sync2_q <= '{sck: 1'b0, cs_n: 1'b1, mosi: 1'b0};
      sck_prev_q <= 1'b0;
      sel_prev_q <= 1'b0;
    end else begin
      sync1_q <= link_in;
      sync2_q <= sync1_q;
      sck_prev_q <= sync2_q.sck;
      sel_prev_q <= ~sync2_q.cs_n;
    end
  end
  logic sck_rise, sck_fall, sel;
  assign sck_rise = sync2_q.sck & ~sck_prev_q;
  assign sck_fall = ~sync2_q.sck & sck_prev_q;
  assign sel = ~sync2_q.cs_n;

  // AHB-Lite address phase capture
  logic [7:0] a_addr_q;
  logic a_wr_q, a_rd_q;
  logic ap_valid;
  assign ap_valid = hsel & hready & htrans[1] & (hsize == HSIZE_WORD);
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      a_addr_q <= 8'h00;
      a_wr_q <= 1'b0;
      a_rd_q <= 1'b0;
    end else if (hready) begin
      a_addr_q <= haddr[7:0];
      a_wr_q <= ap_valid & hwrite;
      a_rd_q <= ap_valid & ~hwrite;
    end
  end

  logic wr_ctrl, wr_icr, wr_data, wr_clr, wr_ien, rd_data, rd_ist;
  assign wr_ctrl = a_wr_q && a_addr_q == ADDR_CTRL;
  assign wr_icr = a_wr_q && a_addr_q == ADDR_IRQ_DMA_CTRL;
  assign wr_data = a_wr_q && a_addr_q == ADDR_DATA;
  assign wr_clr = a_wr_q && a_addr_q == ADDR_INT_CLEAR;
  assign wr_ien = a_wr_q && a_addr_q == ADDR_INT_ENABLE;
  assign rd_data = a_rd_q && a_addr_q == ADDR_DATA;
  assign rd_ist = a_rd_q && a_addr_q == ADDR_INT_STATUS;

  // Control registers
  logic en_q;
  logic srst_pulse;
  assign srst_pulse = wr_ctrl & hwdata[CTRL_SRST_BIT];
  logic [TH_W-1:0] tx_threshold_q, rx_threshold_q;
  logic tx_dma_req_en_q, rx_dma_req_en_q;
  logic tx_thresh_irq_en_q, rx_thresh_irq_en_q;
  logic tx_underrun_irq_en_q, rx_overrun_irq_en_q;
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      en_q <= 1'b0;
    end else if (wr_ctrl) begin
      en_q <= hwdata[CTRL_EN_BIT];
    end
  end
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      tx_threshold_q <= TH_RESET;
      rx_threshold_q <= TH_RESET;
      tx_dma_req_en_q <= 1'b0;
      rx_dma_req_en_q <= 1'b0;
      tx_thresh_irq_en_q <= 1'b0;
      rx_thresh_irq_en_q <= 1'b0;
      tx_underrun_irq_en_q <= 1'b0;
      rx_overrun_irq_en_q <= 1'b0;
    end else if (wr_icr) begin
      tx_threshold_q <= hwdata[IC_TTH_LO +: TH_W];
      rx_threshold_q <= hwdata[IC_RTH_LO +: TH_W];
      tx_dma_req_en_q <= hwdata[IC_TDMA_BIT];
      rx_dma_req_en_q <= hwdata[IC_RDMA_BIT];
      tx_thresh_irq_en_q <= hwdata[IC_TTIE_BIT];
      rx_thresh_irq_en_q <= hwdata[IC_RTIE_BIT];
      tx_underrun_irq_en_q <= hwdata[IC_URIE_BIT];
      rx_overrun_irq_en_q <= hwdata[IC_ORIE_BIT];
    end
  end

  // FIFOs: pointers and levels; depths fixed small to fit level fields
  logic [WORD_W-1:0] tx_mem [TX_DEPTH];
  logic [WORD_W-1:0] rx_mem [RX_DEPTH];
  logic [PTR_W-1:0] tx_wp_q, tx_rp_q, rx_wp_q, rx_rp_q;
  logic [LVL_W-1:0] tx_level_q, rx_level_q;
  logic tx_full, tx_empty, rx_full;
  assign tx_full = tx_level_q == LVL_W'(TX_DEPTH);
  assign tx_empty = tx_level_q == '0;
  assign rx_full = rx_level_q == LVL_W'(RX_DEPTH);

  // Serial engine (slave): shifts only on synchronised external clock
  ssd_state_t state_q;
  logic [BITCNT_W-1:0] bit_q;
  logic [WORD_W-1:0] tx_sh_q, rx_sh_q;
  logic tx_pop, rx_push, underrun_ev, overrun_ev;
  logic word_start, word_done;
  // One word per selection: a word ending with the select still low must
  // not start a stray word that pops the next entry early
  assign word_start = state_q == SSD_IDLE && en_q && sel && !sel_prev_q;
  assign word_done = state_q == SSD_SHIFT && sck_rise && bit_q == LAST_BIT;
  assign tx_pop = word_start & ~tx_empty & ~srst_pulse;
  assign underrun_ev = word_start & tx_empty & ~srst_pulse;
  assign rx_push = word_done & ~rx_full & ~srst_pulse;
  assign overrun_ev = word_done & rx_full & ~srst_pulse;

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_q <= SSD_IDLE;
      bit_q <= '0;
      tx_sh_q <= '0;
      rx_sh_q <= '0;
    end else if (srst_pulse) begin
      state_q <= SSD_IDLE;
      bit_q <= '0;
    end else begin
      unique case (state_q)
        SSD_IDLE: begin
          if (word_start) begin
            state_q <= SSD_SHIFT;
            bit_q <= '0;
            tx_sh_q <= tx_empty ? '0 : tx_mem[tx_rp_q];
          end
        end
        SSD_SHIFT: begin
          // Halts with the external clock; soft reset is the way out
          if (sck_rise) begin
            rx_sh_q <= {rx_sh_q[WORD_W-2:0], sync2_q.mosi};
            bit_q <= bit_q + 1'b1;
            if (bit_q == LAST_BIT) begin
              state_q <= SSD_IDLE;
            end
          end
          if (sck_fall) begin
            tx_sh_q <= {tx_sh_q[WORD_W-2:0], 1'b0};
          end
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      miso_o <= 1'b0;
      miso_oe <= 1'b0;
    end else begin
      miso_o <= tx_sh_q[WORD_W-1];
      miso_oe <= sel & en_q;
    end
  end

  // Transmit FIFO; the storage block also writes received words into rx_mem
  logic tx_push;
  assign tx_push = wr_data & ~tx_full;
  always_ff @(posedge ref_clk) begin
    if (tx_push) begin
      tx_mem[tx_wp_q] <= hwdata;
    end
    if (rx_push) begin
      rx_mem[rx_wp_q] <= {rx_sh_q[WORD_W-2:0], sync2_q.mosi};
    end
  end
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      tx_wp_q <= '0;
      tx_rp_q <= '0;
      tx_level_q <= '0;
    end else begin
      if (tx_push) begin
        tx_wp_q <= tx_wp_q + 1'b1;
      end
      if (tx_pop) begin
        tx_rp_q <= tx_rp_q + 1'b1;
      end
      tx_level_q <= tx_level_q + LVL_W'(tx_push) - LVL_W'(tx_pop);
    end
  end

  // Receive FIFO
  logic rx_pop;
  assign rx_pop = rd_data & (rx_level_q != '0);
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      rx_wp_q <= '0;
      rx_rp_q <= '0;
      rx_level_q <= '0;
    end else begin
      if (rx_push) begin
        rx_wp_q <= rx_wp_q + 1'b1;
      end
      if (rx_pop) begin
        rx_rp_q <= rx_rp_q + 1'b1;
      end
      rx_level_q <= rx_level_q + LVL_W'(rx_push) - LVL_W'(rx_pop);
    end
  end

  // Threshold conditions; zero threshold disables the condition
  logic tx_th_hit, rx_th_hit;
  assign tx_th_hit = (tx_threshold_q != '0) &&
    (tx_level_q <= LVL_W'(tx_threshold_q));
  assign rx_th_hit = (rx_threshold_q != '0) &&
    (rx_level_q >= LVL_W'(rx_threshold_q));

  // Sticky events: set wins over clear by read or clear write
  logic [EV_W-1:0] ev_set, ev_q, ien_q, ev_clr;
  assign ev_set[EV_OVR] = overrun_ev;
  assign ev_set[EV_UND] = underrun_ev;
  assign ev_clr = (wr_clr ? hwdata[EV_W-1:0] : '0) |
    (rd_ist ? ev_q : '0);
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ev_q <= '0;
    end else begin
      ev_q <= (ev_q & ~ev_clr) | ev_set;
    end
  end
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ien_q <= '0;
    end else if (wr_ien) begin
      ien_q <= hwdata[EV_W-1:0];
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      irq <= 1'b0;
      dma_req <= '0;
    end else begin
      irq <= (tx_thresh_irq_en_q & tx_th_hit) |
        (rx_thresh_irq_en_q & rx_th_hit) |
        (tx_underrun_irq_en_q & ev_q[EV_UND]) |
        (rx_overrun_irq_en_q & ev_q[EV_OVR]) |
        (|(ev_q & ien_q));
      dma_req.tx_req <= tx_dma_req_en_q & tx_th_hit;
      dma_req.rx_req <= rx_dma_req_en_q & rx_th_hit;
    end
  end

  // Read mux
  logic [31:0] status_w, icr_w, ist_w, rdata_d;
  always_comb begin
    status_w = '0;
    status_w[ST_TXL_LO +: LVL_W] = tx_level_q;
    status_w[ST_RXL_LO +: LVL_W] = rx_level_q;
    status_w[ST_BUSY_BIT] = state_q == SSD_SHIFT;
    status_w[ST_TNF_BIT] = ~tx_full;
    status_w[ST_RXF_BIT] = rx_full;
    icr_w = '0;
    icr_w[IC_TTH_LO +: TH_W] = tx_threshold_q;
    icr_w[IC_RTH_LO +: TH_W] = rx_threshold_q;
    icr_w[IC_TDMA_BIT] = tx_dma_req_en_q;
    icr_w[IC_RDMA_BIT] = rx_dma_req_en_q;
    icr_w[IC_TTIE_BIT] = tx_thresh_irq_en_q;
    icr_w[IC_RTIE_BIT] = rx_thresh_irq_en_q;
    icr_w[IC_URIE_BIT] = tx_underrun_irq_en_q;
    icr_w[IC_ORIE_BIT] = rx_overrun_irq_en_q;
    ist_w = '0;
    ist_w[EV_W-1:0] = ev_q;
    ist_w[IC_RTIE_BIT] = rx_th_hit;
    ist_w[IC_TTIE_BIT] = tx_th_hit;
    rdata_d = '0;
    if (ap_valid & ~hwrite) begin
      unique case (haddr[7:0])
        ADDR_CTRL: rdata_d[CTRL_EN_BIT] = en_q;
        ADDR_STATUS: rdata_d = status_w;
        ADDR_IRQ_DMA_CTRL: rdata_d = icr_w;
        ADDR_INT_STATUS: rdata_d = ist_w;
        ADDR_DATA: rdata_d = rx_mem[rx_rp_q];
        ADDR_INT_ENABLE: rdata_d[EV_W-1:0] = ien_q;
        default: rdata_d = '0;
      endcase
    end
  end
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      hrdata <= '0;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else if (hready) begin
      hrdata <= rdata_d;
    end
  end

endmodule // ssd_top
`default_nettype wire
